//--- rtl/pirs_pkg.sv
// package: constants, register map and carrier types of the interrupt and reset status block
package pirs_pkg;

  // ----------------------------------------------------------------
  // sources and vectors
  // ----------------------------------------------------------------
  localparam int NSRC = 15;
  localparam int IDX_W = 4;
  localparam int VEC_W = 12;
  typedef logic [VEC_W-1:0] pirs_vec_t;
  localparam pirs_vec_t VEC_RESET = 12'h000;
  // index 0 is the highest priority (level 1), index 14 the lowest (level 15)
  localparam pirs_vec_t VEC_TABLE [NSRC] = '{
    12'h003, 12'h006, 12'h009, 12'h00f, 12'h012, 12'h015, 12'h018, 12'h01b,
    12'h021, 12'h024, 12'h027, 12'h02a, 12'h030, 12'h033, 12'h036};
  localparam int SRC_WATCHDOG = 0;
  localparam int SRC_EXT_A = 1;
  localparam int SRC_FREE_CTR = 2;
  localparam int SRC_EXT_B = 3;
  localparam int SRC_TIME_BASE = 4;
  localparam int SRC_SERIAL_TX = 5;
  localparam int SRC_SERIAL_RX = 6;
  localparam int SRC_SERIAL_ERR = 7;
  localparam int SRC_TIMER_C = 8;
  localparam int SRC_SPI = 9;
  localparam int SRC_TIMER_D = 10;
  localparam int SRC_EXT_C = 11;
  localparam int SRC_CONVERTER = 12;
  localparam int SRC_TIMER_B = 13;
  localparam int SRC_EXT_D = 14;

  // ----------------------------------------------------------------
  // register map (byte offsets) and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_PENDING_A = 8'h00;
  localparam logic [7:0] OFF_PENDING_B = 8'h04;
  localparam logic [7:0] OFF_PENDING_C = 8'h08;
  localparam logic [7:0] OFF_MASK_A = 8'h0c;
  localparam logic [7:0] OFF_MASK_B = 8'h10;
  localparam logic [7:0] OFF_LAST_VEC = 8'h14;
  localparam int LOW_W = 8;
  localparam int HIGH_W = NSRC - LOW_W;
  localparam int STAT_T_BIT = 0;
  localparam int STAT_P_BIT = 1;
  localparam int STAT_GIE_BIT = 2;
  localparam int STAT_SLEEP_BIT = 3;
  localparam int STAT_IDLE_BIT = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_T = 1'b1;
  localparam logic RST_P = 1'b1;
  localparam logic RST_GIE = 1'b0;
  localparam logic [NSRC-1:0] RST_MASK = 15'h0000;
  localparam logic [NSRC-1:0] RST_FLAGS = 15'h0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_IDLE} pirs_pwr_t;

  typedef struct packed {
    logic global_irq_on_op;
    logic global_irq_off_op;
    logic return_from_irq_op;
    logic watchdog_clear_op;
    logic sleep_op;
    logic sleep_sel;
    logic fetch_slot;
    logic pin_reset;
    logic watchdog_reset;
    logic wake_pin;
  } pirs_core_in_t;

  typedef struct packed {
    logic vec_load;
    pirs_vec_t vec_addr;
    logic push_ret;
    logic core_halt;
    logic osc_stop;
    logic gie;
  } pirs_core_out_t;

endpackage : pirs_pkg

//--- rtl/pirs_flag_bank.sv
// pending flag bank: hardware set wins over software clear
`timescale 1ns/1ns
module pirs_flag_bank #(
  parameter int W = 15
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic sync_clr, // reset-pin or watchdog reset
  input wire logic [W-1:0] set_i, // request pulses
  input wire logic [W-1:0] clr_i, // software clear
  output logic [W-1:0] flags // latched flags
);
  typedef struct packed {
    logic [W-1:0] flags;
  } pirs_fb_state_t;

  pirs_fb_state_t st;
  pirs_fb_state_t next_st;

  always_comb begin
    next_st = st;
    // set wins so no request is lost in a clear cycle; enables play no part here
    if (sync_clr) begin
      next_st.flags = set_i;
    end else begin
      next_st.flags = (st.flags & ~clr_i) | set_i; // [R16]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flags = st.flags;
endmodule : pirs_flag_bank

//--- rtl/pirs_prio_enc.sv
// fixed-priority encoder: lowest index wins
`timescale 1ns/1ns
module pirs_prio_enc
  import pirs_pkg::*;
(
  input wire logic [NSRC-1:0] req, // enabled pending requests
  output logic any, // some request present
  output logic [IDX_W-1:0] idx // winning index
);
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = IDX_W'(i); // [R23]
      end
    end
  end
endmodule : pirs_prio_enc

//--- rtl/pirs_irq_ctrl.sv
// vectored interrupt controller with reset and wake-up status, APB register slave
`timescale 1ns/1ns
// Overview of operation
// [R1] fifteen levels; reset is level 0, vector 0000
// [R2] watchdog: global plus own enable, 0003
// [R3] first external: global plus enable, 0006
// [R4] free counter: global plus enable, 0009
// [R5] second external: global plus enable, 000F
// [R6] time base: global plus enable, 0012
// [R7] serial transmit: buffer empty flag, 0015
// [R8] serial receive: global plus enable, 0018
// [R9] serial receive error: gated, 001B
// [R10] timer c 0021, spi 0024, timer d 0027
// [R11] third external 002A, converter done 0030
// [R12] timer b 0033, fourth external 0036 lowest
// [R13] enable op sets, disable op clears global
// [R14] taken request redirects next fetch to vector
// [R15] software clears flag before leaving routine
// [R16] flags latch regardless of any enable
// [R17] return op pops address and sets global
// [R18] power-on sets both; pin reset keeps both
// [R19] watchdog reset clears expiry, keeps power-down
// [R20] watchdog clear op sets both bits
// [R21] sleep op sets expiry, clears power-down
// [R22] sleep stops oscillator; idle halts core only
// [R23] smallest priority number served first
// [R24] accept pushes return, clears global enable
module pirs_irq_ctrl
  import pirs_pkg::*;
(
  input wire logic pclk, // 20 MHz clock
  input wire logic presetn, // power-on reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped
  input wire logic [NSRC-1:0] src_req, // one-cycle source events
  input wire pirs_core_in_t core_in, // core operation strobes
  output pirs_core_out_t core_out // fetch redirect and power
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [NSRC-1:0] mask;
    logic gie;
    logic stat_t;
    logic stat_p;
    pirs_pwr_t pwr;
    logic vec_load;
    pirs_vec_t vec_addr;
    logic push_ret;
    logic core_halt;
    logic osc_stop;
    pirs_vec_t last_vec;
  } pirs_state_t;

  pirs_state_t st;
  pirs_state_t next_st;

  logic [NSRC-1:0] flags;
  logic [NSRC-1:0] clr_vec;
  logic [NSRC-1:0] live;
  logic pend_any;
  logic [IDX_W-1:0] win_idx;
  logic reset_evt;
  logic take;
  logic wr_en;
  logic acc;
  logic [31:0] rd_word;
  logic rd_hit;

  assign reset_evt = core_in.pin_reset | core_in.watchdog_reset;
  assign live = flags & st.mask; // [R2] [R3] [R4] [R5] [R6] [R7] [R8] [R9] [R10] [R11] [R12]
  assign acc = psel & penable;
  assign wr_en = acc & pwrite & st.pready;

  // ----------------------------------------------------------------
  // flags and priority
  // ----------------------------------------------------------------
  always_comb begin
    clr_vec = '0;
    // write one to clear; the service routine relies on it before returning [R15]
    if (wr_en && paddr == OFF_PENDING_A) begin
      clr_vec[LOW_W-1:0] = pwdata[LOW_W-1:0];
    end
    if (wr_en && paddr == OFF_PENDING_B) begin
      clr_vec[NSRC-1:LOW_W] = pwdata[HIGH_W-1:0];
    end
  end

  pirs_flag_bank #(.W(NSRC)) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .sync_clr(reset_evt),
    .set_i(src_req),
    .clr_i(clr_vec),
    .flags(flags)
  );

  pirs_prio_enc u_prio (
    .req(live),
    .any(pend_any),
    .idx(win_idx)
  );

  // requests are taken only at an instruction boundary while running
  assign take = core_in.fetch_slot & (st.pwr == PWR_RUN) & st.gie & pend_any & ~reset_evt; // [R14]

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (paddr)
      OFF_PENDING_A: rd_word[LOW_W-1:0] = flags[LOW_W-1:0];
      OFF_PENDING_B: rd_word[HIGH_W-1:0] = flags[NSRC-1:LOW_W];
      OFF_PENDING_C: begin
        rd_word[STAT_T_BIT] = st.stat_t;
        rd_word[STAT_P_BIT] = st.stat_p;
        rd_word[STAT_GIE_BIT] = st.gie;
        rd_word[STAT_SLEEP_BIT] = (st.pwr == PWR_SLEEP);
        rd_word[STAT_IDLE_BIT] = (st.pwr == PWR_IDLE);
      end
      OFF_MASK_A: rd_word[LOW_W-1:0] = st.mask[LOW_W-1:0];
      OFF_MASK_B: rd_word[HIGH_W-1:0] = st.mask[NSRC-1:LOW_W];
      OFF_LAST_VEC: rd_word[VEC_W-1:0] = st.last_vec;
      default: rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // one wait state: ready rises on the second access cycle
    next_st.pready = acc & ~st.pready;
    next_st.pslverr = acc & ~st.pready & ~rd_hit;
    if (acc && !st.pready && !pwrite) begin
      next_st.prdata = rd_word;
    end
    if (wr_en && paddr == OFF_MASK_A) begin
      next_st.mask[LOW_W-1:0] = pwdata[LOW_W-1:0];
    end
    if (wr_en && paddr == OFF_MASK_B) begin
      next_st.mask[NSRC-1:LOW_W] = pwdata[HIGH_W-1:0];
    end

    // global enable
    if (reset_evt || take) begin
      next_st.gie = 1'b0; // [R24]
    end else if (core_in.global_irq_on_op || core_in.return_from_irq_op) begin
      next_st.gie = 1'b1; // [R13] [R17]
    end else if (core_in.global_irq_off_op) begin
      next_st.gie = 1'b0; // [R13]
    end

    // fetch redirect
    next_st.vec_load = take | reset_evt;
    next_st.push_ret = take; // [R24]
    if (reset_evt) begin
      next_st.vec_addr = VEC_RESET; // [R1]
      next_st.last_vec = VEC_RESET;
    end else if (take) begin
      next_st.vec_addr = VEC_TABLE[win_idx]; // [R14]
      next_st.last_vec = VEC_TABLE[win_idx];
    end

    // wake status bits
    if (core_in.watchdog_reset) begin
      next_st.stat_t = 1'b0; // [R19]
    end else if (core_in.pin_reset) begin
      next_st.stat_t = st.stat_t; // [R18]
    end else if (core_in.watchdog_clear_op) begin
      next_st.stat_t = 1'b1; // [R20]
      next_st.stat_p = 1'b1;
    end else if (core_in.sleep_op && st.pwr == PWR_RUN) begin
      next_st.stat_t = 1'b1; // [R21]
      next_st.stat_p = 1'b0;
    end

    // power state; a plain wake leaves the status bits alone
    if (reset_evt) begin
      next_st.pwr = PWR_RUN;
    end else begin
      case (st.pwr)
        PWR_RUN: begin
          if (core_in.sleep_op) begin
            next_st.pwr = core_in.sleep_sel ? PWR_SLEEP : PWR_IDLE; // [R22]
          end
        end
        PWR_SLEEP: begin
          if (core_in.wake_pin) begin
            next_st.pwr = PWR_RUN;
          end
        end
        PWR_IDLE: begin
          // peripherals keep running, so any enabled flag wakes the core
          if (pend_any) begin
            next_st.pwr = PWR_RUN; // [R22]
          end
        end
        default: next_st.pwr = PWR_RUN;
      endcase
    end

    // decoded ahead of the flop so both power outputs leave straight from registers
    next_st.core_halt = (next_st.pwr != PWR_RUN); // [R22]
    next_st.osc_stop = (next_st.pwr == PWR_SLEEP);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.mask <= RST_MASK;
      st.gie <= RST_GIE;
      st.stat_t <= RST_T; // [R18]
      st.stat_p <= RST_P;
      st.pwr <= PWR_RUN;
      st.vec_addr <= VEC_RESET; // [R1]
      st.last_vec <= VEC_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign core_out.vec_load = st.vec_load;
  assign core_out.vec_addr = st.vec_addr;
  assign core_out.push_ret = st.push_ret;
  assign core_out.core_halt = st.core_halt;
  assign core_out.osc_stop = st.osc_stop;
  assign core_out.gie = st.gie;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_take;
    take ##0 (live != '0);
  endsequence
  sequence s_redirect;
    core_out.vec_load && core_out.push_ret && !core_out.gie;
  endsequence

  take_gated_a: assert property (take |-> st.gie && live[win_idx]) // [R2]
    else $error("request taken without both enables");
  take_vector_a: assert property (s_take |=> s_redirect // [R14]
    and (core_out.vec_addr == VEC_TABLE[$past(win_idx)]))
    else $error("taken request did not redirect fetch to its vector");
  prio_lowest_a: assert property (take |-> (live & ((15'h0001 << win_idx) - 15'h0001)) == '0) // [R23]
    else $error("higher priority request was passed over");
  reset_vector_a: assert property (reset_evt |=> core_out.vec_load // [R1]
    && core_out.vec_addr == VEC_RESET && !core_out.push_ret && !core_out.gie)
    else $error("reset did not restart at vector zero");
  flag_latch_a: assert property ((src_req != '0) |=> (flags & $past(src_req)) == $past(src_req)) // [R16]
    else $error("request not latched in its flag");
  gie_set_a: assert property ((core_in.global_irq_on_op || core_in.return_from_irq_op) // [R17]
    && !take && !reset_evt |=> core_out.gie)
    else $error("enable or return op did not set global enable");
  gie_clear_a: assert property (core_in.global_irq_off_op && !core_in.global_irq_on_op // [R13]
    && !core_in.return_from_irq_op |=> !core_out.gie)
    else $error("disable op did not clear global enable");
  wdt_status_a: assert property (core_in.watchdog_reset |=> !st.stat_t && $stable(st.stat_p)) // [R19]
    else $error("watchdog reset status bits wrong");
  pin_status_a: assert property (core_in.pin_reset && !core_in.watchdog_reset // [R18]
    |=> $stable(st.stat_t) && $stable(st.stat_p))
    else $error("pin reset changed status bits");
  watchdog_clear_op_status_a: assert property (core_in.watchdog_clear_op && !reset_evt |=> st.stat_t && st.stat_p) // [R20]
    else $error("watchdog clear op did not set status bits");
  sleep_status_a: assert property (core_in.sleep_op && !core_in.watchdog_clear_op && !reset_evt // [R21]
    && st.pwr == PWR_RUN |=> st.stat_t && !st.stat_p)
    else $error("sleep op status bits wrong");
  sleep_halt_a: assert property (core_in.sleep_op && !reset_evt && st.pwr == PWR_RUN // [R22]
    |=> core_out.core_halt && (core_out.osc_stop == $past(core_in.sleep_sel)))
    else $error("sleep or idle entry wrong");
  apb_answer_a: assert property (psel && penable && !st.pready |=> pready ##1 !pready)
    else $error("apb answer not in one wait state");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("apb error shown without ready");

  // ----------------------------------------------------------------
  // power, redirect and flag checks
  // ----------------------------------------------------------------
  // sleep is left only through the wake pin or a reset event
  sequence s_asleep;
    st.pwr == PWR_SLEEP && !reset_evt;
  endsequence
  // idle needs no global enable to wake, only an enabled flag
  sequence s_idle_wake;
    st.pwr == PWR_IDLE && pend_any && !reset_evt;
  endsequence
  sequence s_no_load;
    !core_out.vec_load;
  endsequence

  sleep_hold_a: assert property (s_asleep ##0 !core_in.wake_pin // [R22]
    |=> core_out.core_halt && core_out.osc_stop)
    else $error("sleep state left without a wake event");
  sleep_wake_a: assert property (s_asleep ##0 core_in.wake_pin // [R22]
    |=> !core_out.core_halt && !core_out.osc_stop)
    else $error("wake pin did not restart the core");
  idle_wake_a: assert property (s_idle_wake |=> !core_out.core_halt) // [R22]
    else $error("pending enabled request did not wake the idle core");
  idle_osc_a: assert property (st.pwr == PWR_IDLE |-> core_out.core_halt && !core_out.osc_stop) // [R22]
    else $error("idle state stopped the oscillator or ran the core");
  reset_run_a: assert property (reset_evt |=> !core_out.core_halt && !core_out.osc_stop) // [R19]
    else $error("reset event did not bring the core back to run");
  halt_refuse_a: assert property (core_out.core_halt |-> !take) // [R22]
    else $error("request taken while the core was halted");
  gie_refuse_a: assert property (!core_out.gie |-> !take) // [R14]
    else $error("request taken with global enable clear");
  ret_pulse_a: assert property (core_out.push_ret |=> !core_out.push_ret) // [R24]
    else $error("return push lasted more than one cycle");
  ret_load_a: assert property (core_out.push_ret |-> core_out.vec_load) // [R24]
    else $error("return push without a vector load");
  vec_hold_a: assert property (s_no_load |-> $stable(core_out.vec_addr)) // [R14]
    else $error("vector address moved without a load");
  last_vec_a: assert property (core_out.vec_load |-> st.last_vec == core_out.vec_addr) // [R14]
    else $error("last vector record differs from the loaded vector");
  // a flag may only drop through a clear write or a reset event
  flag_keep_a: assert property (!reset_evt && clr_vec == '0 // [R16]
    |=> (flags & $past(flags)) == $past(flags))
    else $error("pending flag lost without a clear");
  reset_flags_a: assert property (reset_evt |=> flags == $past(src_req))
    else $error("reset event left stale pending flags");
  mask_kept_a: assert property (reset_evt && !wr_en |=> $stable(st.mask))
    else $error("reset event changed the enable masks");
endmodule : pirs_irq_ctrl

//--- tb/pirs_core_model.sv
// cpu core stand-in: instruction boundaries, op strobes and count of vector loads
`timescale 1ns/1ns
module pirs_core_model
  import pirs_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // power-on reset, low
  input wire logic run, // core executing
  input wire logic [9:0] op, // op strobes from the bench
  input wire pirs_core_out_t core_out, // redirect and power from block
  output pirs_core_in_t core_in, // strobes to block
  output logic [7:0] taken // vector loads seen
);
  always_comb begin
    core_in = op;
    // a halted core offers no instruction boundary
    core_in.fetch_slot = run & ~core_out.core_halt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taken <= 8'h00;
    end else if (core_out.vec_load) begin
      taken <= taken + 8'h01;
    end
  end
endmodule : pirs_core_model

//--- tb/prioritized_interrupt_and_reset_status_tb.sv
// testbench: vectors, priority, gating and reset status of the interrupt block
`timescale 1ns/1ns
module prioritized_interrupt_and_reset_status_tb;
  import pirs_pkg::*;
  localparam logic [9:0] OP_ON = 10'h200;
  localparam logic [9:0] OP_OFF = 10'h100;
  localparam logic [9:0] OP_RET = 10'h080;
  localparam logic [9:0] OP_WDC = 10'h040;
  localparam logic [9:0] OP_SLP = 10'h020;
  localparam logic [9:0] OP_SSEL = 10'h010;
  localparam logic [9:0] OP_PIN = 10'h004;
  localparam logic [9:0] OP_WDR = 10'h002;
  localparam logic [9:0] OP_WAKE = 10'h001;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NSRC-1:0] src_req = '0;
  logic [9:0] op = 10'h000;
  logic run = 1'b0;
  pirs_core_in_t core_in;
  pirs_core_out_t core_out;
  logic [7:0] taken;
  logic [7:0] exp_taken = 8'h00;
  logic [31:0] rd;
  logic er;
  int miscompares = 0;
  int tests_run = 0;
  logic [11:0] exp_vec [15] = '{12'h003, 12'h006, 12'h009, 12'h00f, 12'h012, 12'h015, 12'h018, 12'h01b,
    12'h021, 12'h024, 12'h027, 12'h02a, 12'h030, 12'h033, 12'h036};

  always #25 pclk = ~pclk;

  pirs_irq_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_req(src_req), .core_in(core_in), .core_out(core_out));

  pirs_core_model core (.pclk(pclk), .presetn(presetn), .run(run), .op(op), .core_out(core_out),
    .core_in(core_in), .taken(taken));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    tests_run++;
    if (got !== x) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, x, got);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, x, rd);
    chk("pslverr", 32'(xe), 32'(er));
  endtask : rd_chk

  // low half then high half of a fifteen-bit field
  task wr2(input logic [7:0] a, input logic [14:0] m);
    apb(1'b1, a, {24'h0, m[7:0]});
    apb(1'b1, a + 8'h04, {25'h0, m[14:8]});
  endtask : wr2

  task op_pulse(input logic [9:0] v);
    @(posedge pclk);
    op <= v;
    @(posedge pclk);
    op <= 10'h000;
  endtask : op_pulse

  task src_pulse(input logic [14:0] m);
    @(posedge pclk);
    src_req <= m;
    @(posedge pclk);
    src_req <= '0;
  endtask : src_pulse

  task take(input logic [11:0] v);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (core_out.vec_load !== 1'b1 && n < 30);
    if (core_out.vec_load !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    exp_taken++;
    chk("vec_addr", {20'h0, v}, {20'h0, core_out.vec_addr});
    chk("push_ret", 32'h1, 32'(core_out.push_ret));
    chk("gie", 32'h0, 32'(core_out.gie));
  endtask : take

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rd_chk(8'h08, 32'h3, 1'b0, "status");
    rd_chk(8'h0c, 32'h0, 1'b0, "mask_a");
    rd_chk(8'h18, 32'h0, 1'b1, "unmapped");
  endtask : t_reset

  task t_latch;
    src_pulse(15'h7fff);
    rd_chk(8'h00, 32'hff, 1'b0, "flags_a");
    rd_chk(8'h04, 32'h7f, 1'b0, "flags_b");
    chk("taken", 32'(exp_taken), 32'(taken));
    wr2(8'h00, 15'h7fff);
    rd_chk(8'h00, 32'h0, 1'b0, "flags_a");
  endtask : t_latch

  task t_vectors;
    for (int i = 0; i < 15; i++) begin
      wr2(8'h0c, 15'(1 << i));
      src_pulse(15'(1 << i));
      op_pulse(OP_ON);
      take(exp_vec[i]);
      wr2(8'h00, 15'(1 << i));
      op_pulse(OP_RET);
      #1;
      chk("gie", 32'h1, 32'(core_out.gie));
      repeat (3) @(posedge pclk);
      chk("taken", 32'(exp_taken), 32'(taken));
      op_pulse(OP_OFF);
    end
  endtask : t_vectors

  task t_priority;
    wr2(8'h0c, 15'h7fff);
    rd_chk(8'h10, 32'h7f, 1'b0, "mask_b");
    src_pulse(15'h4088);
    op_pulse(OP_ON);
    take(12'h00f);
    wr2(8'h00, 15'h0008);
    op_pulse(OP_RET);
    take(12'h01b);
    wr2(8'h00, 15'h0080);
    op_pulse(OP_RET);
    take(12'h036);
    rd_chk(8'h14, 32'h036, 1'b0, "last_vec");
    wr2(8'h00, 15'h4000);
  endtask : t_priority

  task t_gating;
    wr2(8'h0c, 15'h7ffe);
    src_pulse(15'h0001);
    op_pulse(OP_ON);
    repeat (4) @(posedge pclk);
    chk("taken", 32'(exp_taken), 32'(taken));
    rd_chk(8'h08, 32'h7, 1'b0, "status gie");
    op_pulse(OP_OFF);
    wr2(8'h0c, 15'h0001);
    repeat (4) @(posedge pclk);
    chk("taken", 32'(exp_taken), 32'(taken));
    op_pulse(OP_ON);
    take(12'h003);
    wr2(8'h00, 15'h0001);
  endtask : t_gating

  task t_status;
    op_pulse(OP_WDR);
    #1;
    exp_taken++;
    chk("reset vec", 32'h1000, {19'h0, core_out.vec_load, core_out.vec_addr});
    rd_chk(8'h08, 32'h2, 1'b0, "status");
    op_pulse(OP_WDC);
    rd_chk(8'h08, 32'h3, 1'b0, "status");
    op_pulse(OP_SLP | OP_SSEL);
    #1;
    chk("halt osc", 32'h3, {30'h0, core_out.core_halt, core_out.osc_stop});
    rd_chk(8'h08, 32'h9, 1'b0, "status");
    op_pulse(OP_WAKE);
    #1;
    chk("halt", 32'h0, 32'(core_out.core_halt));
    rd_chk(8'h08, 32'h1, 1'b0, "status");
    op_pulse(OP_PIN);
    exp_taken++;
    rd_chk(8'h08, 32'h1, 1'b0, "status");
    wr2(8'h0c, 15'h0010);
    op_pulse(OP_SLP);
    #1;
    chk("halt osc", 32'h2, {30'h0, core_out.core_halt, core_out.osc_stop});
    rd_chk(8'h08, 32'h11, 1'b0, "status");
    src_pulse(15'h0010);
    repeat (3) @(posedge pclk);
    #1;
    chk("idle wake", 32'h0, 32'(core_out.core_halt));
    wr2(8'h00, 15'h0010);
    op_pulse(OP_SLP | OP_SSEL);
    op_pulse(OP_WDR);
    exp_taken++;
    rd_chk(8'h08, 32'h0, 1'b0, "status");
    chk("taken", 32'(exp_taken), 32'(taken));
  endtask : t_status

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    run <= 1'b1;
    t_reset();
    t_latch();
    t_vectors();
    t_priority();
    t_gating();
    t_status();
    finish_test();
  end
endmodule : prioritized_interrupt_and_reset_status_tb
